//--- hw/fsp_pkg.sv
// Package of constants for the flash status register and parameter table block.
// Contract
// - With the lock bit set and the protect pin low, a register write is ignored entirely.
// - With the lock bit clear, register writes go ahead whatever the protect pin does.
// - Program and erase errors set read-only flags in bits 6 and 5, both zero by default.
// - Register write, program and erase are accepted only while the write latch is set; a bus write to the config offset changes bit 3 without the latch.
// - Only write enable and write disable change the write latch; a register write does not.
// - The busy flag is 1 while any operation runs and 0 in standby.
// - The protection bits are volatile when config bit 3 is 1, non-volatile otherwise.
// - Parameter offset 12h reads E6h.
// - Parameter offsets 13h through 1Dh read FFh.
// - The mode and dummy fields at 18h and 1Ch read all ones.
// - Offset 1Eh reads 0Ch for hybrid and 12h for uniform layouts.
// - Offset 1Fh reads 20h for hybrid and D8h for uniform layouts.
// - Offset 20h reads 10h hybrid or 00h uniform, and 21h reads D8h.
// - Offsets 22h and 24h read 00h, and 23h and 25h read FFh.
// - Config bit 3 selects volatile (1) or non-volatile (0) protection storage.
package fsp_pkg;
    localparam logic [7:0] FSP_OFF_STATUS = 8'h00;
    localparam logic [7:0] FSP_OFF_CONFIG = 8'h04;
    localparam logic [7:0] FSP_OFF_CMD = 8'h08;
    localparam logic [7:0] FSP_OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0] FSP_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] FSP_OFF_PARAM_ADDR = 8'h14;
    localparam logic [7:0] FSP_OFF_PARAM_DATA = 8'h18;
    localparam logic [7:0] FSP_OFF_NV_BP = 8'h1C;
    localparam int FSP_BIT_LOCK = 7;
    localparam int FSP_BIT_PERR = 6;
    localparam int FSP_BIT_EERR = 5;
    localparam int FSP_BIT_BP_HI = 4;
    localparam int FSP_BIT_BP_LO = 2;
    localparam int FSP_BIT_LATCH = 1;
    localparam int FSP_BIT_BUSY = 0;
    localparam int FSP_BIT_VOLSEL = 3;
    localparam logic [7:0] FSP_STATUS_RESET = 8'h00;
    localparam logic [2:0] FSP_BP_RESET = 3'h0;
    localparam logic [7:0] FSP_CMD_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] FSP_CMD_WRITE_DISABLE_COMMAND = 8'h04;
    localparam logic [7:0] FSP_CMD_WRR = 8'h01;
    localparam logic [7:0] FSP_CMD_PROG = 8'h02;
    localparam logic [7:0] FSP_CMD_ERASE = 8'hD8;
    localparam logic [7:0] FSP_CMD_CLRERR = 8'h30;
    localparam int FSP_IRQ_DONE = 0;
    localparam int FSP_IRQ_PERR = 1;
    localparam int FSP_IRQ_EERR = 2;
    localparam int FSP_IRQ_BLOCKED = 3;
    localparam int FSP_CLK_HZ = 10_000_000;
    localparam int FSP_WRR_TIME_US = 20;
    localparam int FSP_PROG_TIME_US = 50;
    localparam int FSP_ERASE_TIME_US = 400;
    localparam int FSP_WRR_CYC = FSP_WRR_TIME_US * (FSP_CLK_HZ / 1_000_000);
    localparam int FSP_PROG_CYC = FSP_PROG_TIME_US * (FSP_CLK_HZ / 1_000_000);
    localparam int FSP_ERASE_CYC = FSP_ERASE_TIME_US * (FSP_CLK_HZ / 1_000_000);
    localparam logic [7:0] FSP_P_DUALQUAD = 8'hE6;
    localparam logic [7:0] FSP_P_RSVD = 8'hFF;
    localparam logic [7:0] FSP_P_NONE_SZ = 8'h00;
    localparam logic [7:0] FSP_P_S1SZ_HYB = 8'h0C;
    localparam logic [7:0] FSP_P_S1SZ_UNI = 8'h12;
    localparam logic [7:0] FSP_P_S1OP_HYB = 8'h20;
    localparam logic [7:0] FSP_P_S1OP_UNI = 8'hD8;
    localparam logic [7:0] FSP_P_S2SZ_HYB = 8'h10;
    localparam logic [7:0] FSP_P_S2SZ_UNI = 8'h00;
    localparam logic [7:0] FSP_P_S2OP = 8'hD8;
    localparam logic [7:0] FSP_PA_DUALQUAD = 8'h12;
    localparam logic [7:0] FSP_PA_RSVD_LO = 8'h13;
    localparam logic [7:0] FSP_PA_RSVD_HI = 8'h1D;
    localparam logic [7:0] FSP_PA_S1SZ = 8'h1E;
    localparam logic [7:0] FSP_PA_S1OP = 8'h1F;
    localparam logic [7:0] FSP_PA_S2SZ = 8'h20;
    localparam logic [7:0] FSP_PA_S2OP = 8'h21;
    localparam logic [7:0] FSP_PA_S3SZ = 8'h22;
    localparam logic [7:0] FSP_PA_S3OP = 8'h23;
    localparam logic [7:0] FSP_PA_S4SZ = 8'h24;
    localparam logic [7:0] FSP_PA_S4OP = 8'h25;
    localparam logic [1:0] FSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] FSP_RESP_SLVERR = 2'h2;
endpackage

//--- hw/fsp_top.sv
// Flash status register, command engine and parameter table behind AXI4-Lite.
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fsp_top
    import fsp_pkg::*;
#(
    parameter int WRR_CYC = FSP_WRR_CYC,
    parameter int PROG_CYC = FSP_PROG_CYC,
    parameter int ERASE_CYC = FSP_ERASE_CYC,
    parameter bit UNIFORM = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Pins and array status
    input wire logic write_protect_n_i,
    input wire logic prog_fail_i,
    input wire logic erase_fail_i,
    // Status and interrupt
    output logic [7:0] status_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FSP_IDLE, FSP_WRR, FSP_PROG, FSP_ERASE} fsp_op_t;
    fsp_op_t op_reg, op_next;
    logic [31:0] cnt_reg;
    logic lock_reg, perr_reg, eerr_reg, latch_reg;
    logic [2:0] bp_reg, bp_nv_reg;
    logic volsel_reg;
    logic [7:0] wrr_data_reg, wrr_cfg_reg;
    logic [3:0] irq_stat_reg, irq_mask_reg;
    logic [7:0] param_addr_reg;
    logic [1:0] wp_sync_reg;
    logic [1:0] pf_sync_reg, ef_sync_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg, arready_reg, rvalid_reg;
    logic awready_reg, wready_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] status_reg;
    logic irq_reg;

    // ------------------------------------------------------------
    // Parameter table lookup
    // ------------------------------------------------------------
    function automatic logic [7:0] fsp_param(input logic [7:0] a, input logic uni);
        logic [7:0] v;
        v = FSP_P_RSVD;
        if (a == FSP_PA_DUALQUAD) v = FSP_P_DUALQUAD;
        else if (a >= FSP_PA_RSVD_LO && a <= FSP_PA_RSVD_HI) v = FSP_P_RSVD;
        else if (a == FSP_PA_S1SZ) v = uni ? FSP_P_S1SZ_UNI : FSP_P_S1SZ_HYB;
        else if (a == FSP_PA_S1OP) v = uni ? FSP_P_S1OP_UNI : FSP_P_S1OP_HYB;
        else if (a == FSP_PA_S2SZ) v = uni ? FSP_P_S2SZ_UNI : FSP_P_S2SZ_HYB;
        else if (a == FSP_PA_S2OP) v = FSP_P_S2OP;
        else if (a == FSP_PA_S3SZ || a == FSP_PA_S4SZ) v = FSP_P_NONE_SZ;
        else if (a == FSP_PA_S3OP || a == FSP_PA_S4OP) v = FSP_P_RSVD;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire logic wr_cmd = wr_fire && aw_addr_reg == FSP_OFF_CMD && w_strb_reg[0];
    wire logic wr_cfg = wr_fire && aw_addr_reg == FSP_OFF_CONFIG && w_strb_reg[0];
    wire logic wr_mask = wr_fire && aw_addr_reg == FSP_OFF_IRQ_MASK && w_strb_reg[0];
    wire logic wr_paddr = wr_fire && aw_addr_reg == FSP_OFF_PARAM_ADDR && w_strb_reg[0];
    wire logic wr_known = aw_addr_reg == FSP_OFF_CMD || aw_addr_reg == FSP_OFF_CONFIG
        || aw_addr_reg == FSP_OFF_IRQ_MASK || aw_addr_reg == FSP_OFF_PARAM_ADDR
        || aw_addr_reg == FSP_OFF_STATUS || aw_addr_reg == FSP_OFF_IRQ_STAT
        || aw_addr_reg == FSP_OFF_PARAM_DATA || aw_addr_reg == FSP_OFF_NV_BP;
    wire logic [7:0] cmd = w_data_reg[7:0];
    wire logic rd_fire = s_axi_arvalid_i && arready_reg;
    wire logic rd_stat_clr = rd_fire && s_axi_araddr_i == FSP_OFF_IRQ_STAT;
    wire logic idle = op_reg == FSP_IDLE;
    wire logic wp_low = !wp_sync_reg[1];
    wire logic locked = lock_reg && wp_low;
    wire logic start_wrr = wr_cmd && cmd == FSP_CMD_WRR && idle && latch_reg && !locked;
    wire logic start_prog = wr_cmd && cmd == FSP_CMD_PROG && idle && latch_reg;
    wire logic start_erase = wr_cmd && cmd == FSP_CMD_ERASE && idle && latch_reg;
    wire logic blocked = wr_cmd && !idle | (cmd == FSP_CMD_WRR && (locked || !latch_reg));
    wire logic op_done = !idle && cnt_reg == 32'h0000_0001;
    wire logic perr_set = op_reg == FSP_PROG && pf_sync_reg[1];
    wire logic eerr_set = op_reg == FSP_ERASE && ef_sync_reg[1];
    wire logic [2:0] bp_now = volsel_reg ? bp_reg : bp_nv_reg;
    wire logic [7:0] status_now = {lock_reg, perr_reg, eerr_reg, bp_now, latch_reg,
        !idle};
    wire logic [3:0] ev = {blocked, eerr_set & op_done, perr_set & op_done, op_done};

    always_comb begin
        op_next = op_reg;
        if (start_wrr) op_next = FSP_WRR;
        else if (start_prog) op_next = FSP_PROG;
        else if (start_erase) op_next = FSP_ERASE;
        else if (op_done) op_next = FSP_IDLE;
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wp_sync_reg <= 2'h3;
            pf_sync_reg <= 2'h0;
            ef_sync_reg <= 2'h0;
        end else begin
            wp_sync_reg <= {wp_sync_reg[0], write_protect_n_i};
            pf_sync_reg <= {pf_sync_reg[0], prog_fail_i};
            ef_sync_reg <= {ef_sync_reg[0], erase_fail_i};
        end
    end

    // ------------------------------------------------------------
    // Operation engine and status bits
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            op_reg <= FSP_IDLE;
            cnt_reg <= 32'h0;
        end else begin
            op_reg <= op_next;
            if (start_wrr) cnt_reg <= 32'(WRR_CYC);
            else if (start_prog) cnt_reg <= 32'(PROG_CYC);
            else if (start_erase) cnt_reg <= 32'(ERASE_CYC);
            else if (!idle) cnt_reg <= cnt_reg - 32'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            latch_reg <= 1'b0;
            perr_reg <= 1'b0;
            eerr_reg <= 1'b0;
        end else begin
            // A latch command that arrives while busy is refused like any other command.
            if (idle && wr_cmd && cmd == FSP_CMD_WRITE_ENABLE_COMMAND) latch_reg <= 1'b1;
            else if (idle && wr_cmd && cmd == FSP_CMD_WRITE_DISABLE_COMMAND) latch_reg <= 1'b0;
            if (perr_set) perr_reg <= 1'b1;
            else if (wr_cmd && cmd == FSP_CMD_CLRERR && idle) perr_reg <= 1'b0;
            if (eerr_set) eerr_reg <= 1'b1;
            else if (wr_cmd && cmd == FSP_CMD_CLRERR && idle) eerr_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wrr_data_reg <= FSP_STATUS_RESET;
            wrr_cfg_reg <= 8'h00;
            lock_reg <= 1'b0;
            bp_reg <= FSP_BP_RESET;
            bp_nv_reg <= FSP_BP_RESET;
            volsel_reg <= 1'b0;
        end else begin
            if (start_wrr) begin
                wrr_data_reg <= w_data_reg[15:8];
                wrr_cfg_reg <= w_data_reg[23:16];
            end
            if (op_done && op_reg == FSP_WRR) begin
                lock_reg <= wrr_data_reg[FSP_BIT_LOCK];
                volsel_reg <= wrr_cfg_reg[FSP_BIT_VOLSEL];
                // The select bit written together with the protect bits decides their store.
                if (wrr_cfg_reg[FSP_BIT_VOLSEL]) bp_reg <= wrr_data_reg[FSP_BIT_BP_HI:FSP_BIT_BP_LO];
                else bp_nv_reg <= wrr_data_reg[FSP_BIT_BP_HI:FSP_BIT_BP_LO];
            end
            if (wr_cfg && idle && !locked) volsel_reg <= w_data_reg[FSP_BIT_VOLSEL];
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            irq_reg <= 1'b0;
            status_reg <= FSP_STATUS_RESET;
        end else begin
            irq_stat_reg <= (rd_stat_clr ? 4'h0 : irq_stat_reg) | ev;
            if (wr_mask) irq_mask_reg <= w_data_reg[3:0];
            irq_reg <= |(((rd_stat_clr ? 4'h0 : irq_stat_reg) | ev) & irq_mask_reg);
            status_reg <= status_now;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= FSP_RESP_OKAY;
            param_addr_reg <= 8'h00;
        end else begin
            if (s_axi_awvalid_i && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
            end
            if (s_axi_wvalid_i && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                wready_reg <= 1'b0;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
                if (wr_paddr) param_addr_reg <= w_data_reg[7:0];
            end
            if (bvalid_reg && s_axi_bready_i) begin
                bvalid_reg <= 1'b0;
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    wire logic [31:0] rd_mux =
        s_axi_araddr_i == FSP_OFF_STATUS ? {24'h0, status_now} :
        s_axi_araddr_i == FSP_OFF_CONFIG ? {28'h0, volsel_reg, 3'h0} :
        s_axi_araddr_i == FSP_OFF_IRQ_STAT ? {28'h0, irq_stat_reg} :
        s_axi_araddr_i == FSP_OFF_IRQ_MASK ? {28'h0, irq_mask_reg} :
        s_axi_araddr_i == FSP_OFF_PARAM_ADDR ? {24'h0, param_addr_reg} :
        s_axi_araddr_i == FSP_OFF_PARAM_DATA ? {24'h0, fsp_param(param_addr_reg, UNIFORM)} :
        s_axi_araddr_i == FSP_OFF_NV_BP ? {29'h0, bp_nv_reg} : 32'h0;
    wire logic rd_known = s_axi_araddr_i[1:0] == 2'h0 && s_axi_araddr_i <= FSP_OFF_NV_BP;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= FSP_RESP_OKAY;
        end else begin
            arready_reg <= !rvalid_reg && !arready_reg && s_axi_arvalid_i;
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_known ? rd_mux : 32'h0;
                rresp_reg <= rd_known ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign status_o = status_reg;
    assign irq_o = irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence wrr_cmd_s;
        wr_cmd && cmd == FSP_CMD_WRR;
    endsequence
    locked_ignore_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wrr_cmd_s and locked |=> op_reg != FSP_WRR || $past(op_reg) == FSP_WRR)
        else $error("locked write accepted");
    unlocked_ok_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wrr_cmd_s and !lock_reg and latch_reg and idle |=> op_reg == FSP_WRR)
        else $error("unlocked write refused");
    perr_sticky_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        perr_set |=> perr_reg)
        else $error("program error not flagged");
    latch_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        idle && !latch_reg |=> idle)
        else $error("operation started without latch");
    latch_only_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(wr_cmd && (cmd == FSP_CMD_WRITE_ENABLE_COMMAND || cmd == FSP_CMD_WRITE_DISABLE_COMMAND)) |=> $stable(latch_reg))
        else $error("latch changed by other command");
    busy_bit_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_prog |=> status_now[FSP_BIT_BUSY] [*2])
        else $error("busy not shown");
    bp_volsel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(op_done && op_reg == FSP_WRR && !wrr_cfg_reg[FSP_BIT_VOLSEL]) |=> $stable(bp_nv_reg))
        else $error("wrong protect storage");
    param_e6_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_fire && s_axi_araddr_i == FSP_OFF_PARAM_DATA && param_addr_reg == FSP_PA_DUALQUAD
        |=> rdata_reg[7:0] == FSP_P_DUALQUAD)
        else $error("parameter 12h wrong");
    param_s4_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_fire && s_axi_araddr_i == FSP_OFF_PARAM_DATA && param_addr_reg == FSP_PA_S4OP
        |=> rdata_reg[7:0] == FSP_P_RSVD)
        else $error("parameter 25h wrong");
endmodule

//--- tb/fsp_host_model.sv
// Host model that masters the register port and polls the device like a flash controller.
`timescale 1ns/1ps
module fsp_host_model
    import fsp_pkg::*;
(
    // Clock
    input wire logic ref_clk_i,
    // Write channels
    output logic [7:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic [1:0] bresp_i,
    input wire logic bvalid_i,
    output logic bready_o,
    // Read channels
    output logic [7:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    int errs = 0;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
        wstrb_o = 4'hF;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk_i);
            if (awvalid_o && awready_i) awvalid_o <= 1'b0;
            if (wvalid_o && wready_i) wvalid_o <= 1'b0;
            if (bvalid_i) break;
        end
        if (n == 200) errs++;
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge ref_clk_i);
            if (arvalid_o && arready_i) arvalid_o <= 1'b0;
            if (rvalid_i) break;
        end
        if (n == 200) errs++;
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
    endtask
    // Polls the status byte until the busy flag drops, as a host must before its next command.
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        for (n = 0; n < 200; n++) begin
            rd(FSP_OFF_STATUS, d, r);
            if (d[FSP_BIT_BUSY] === 1'b0) break;
        end
        if (n == 200) errs++;
    endtask
endmodule

//--- tb/tb.sv
// Self-checking testbench for the flash status register and parameter table block.
`timescale 1ns/1ps
module tb;
    import fsp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic write_protect_n_i = 1'b1;
    logic prog_fail_i = 1'b0;
    logic erase_fail_i = 1'b0;
    logic [7:0] awaddr, araddr, status_o;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq_o;
    int n_fail = 0;
    int compares = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    fsp_top #(.WRR_CYC(20), .PROG_CYC(30), .ERASE_CYC(40), .UNIFORM(1'b0)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .write_protect_n_i(write_protect_n_i), .prog_fail_i(prog_fail_i),
        .erase_fail_i(erase_fail_i), .status_o(status_o), .irq_o(irq_o));
    fsp_host_model host (
        .ref_clk_i(ref_clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
        .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
        .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
        .rvalid_i(rvalid), .rready_o(rready));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        n_fail = n_fail + host.errs;
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic rreg(input logic [7:0] a);
        host.rd(a, rd, rs);
    endtask
    task automatic cmd(input logic [31:0] d, input bit idle);
        host.wr(FSP_OFF_CMD, d, rs);
        if (idle) host.wait_idle();
    endtask
    function automatic logic [7:0] exp_param(input logic [7:0] a);
        case (a)
            FSP_PA_DUALQUAD: return 8'hE6;
            8'h1E: return 8'h0C;
            8'h1F: return 8'h20;
            8'h20: return 8'h10;
            8'h21: return 8'hD8;
            8'h22, 8'h24: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic t_reset();
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_0000);
        rreg(8'h40);
        check({30'h0, rs}, {30'h0, FSP_RESP_SLVERR});
        check(rd, 32'h0000_0000);
        host.wr(8'h40, 32'h0000_0000, rs);
        check({30'h0, rs}, {30'h0, FSP_RESP_SLVERR});
    endtask
    task automatic t_latch();
        cmd(32'h0000_1C01, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_0000);
        cmd(32'h0000_0006, 1'b1);
        cmd(32'h0000_FF01, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, status_o[0]}, 32'h1);
        host.wait_idle();
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_009E);
    endtask
    task automatic t_lock();
        write_protect_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        cmd(32'h0008_0001, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_009E);
        rreg(FSP_OFF_CONFIG);
        check(rd, 32'h0000_0000);
        write_protect_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        cmd(32'h0000_1C01, 1'b1);
        write_protect_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        cmd(32'h0000_0801, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_000A);
        write_protect_n_i <= 1'b1;
    endtask
    task automatic t_vol();
        cmd(32'h0008_1C01, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_001E);
        rreg(FSP_OFF_CONFIG);
        check(rd, 32'h0000_0008);
        rreg(FSP_OFF_NV_BP);
        check(rd, 32'h0000_0002);
    endtask
    task automatic t_err();
        rreg(FSP_OFF_IRQ_STAT);
        host.wr(FSP_OFF_IRQ_MASK, 32'h0, rs);
        prog_fail_i <= 1'b1;
        cmd({24'h0, FSP_CMD_PROG}, 1'b1);
        prog_fail_i <= 1'b0;
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_005E);
        erase_fail_i <= 1'b1;
        cmd({24'h0, FSP_CMD_ERASE}, 1'b1);
        erase_fail_i <= 1'b0;
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_007E);
        check({31'h0, irq_o}, 32'h0);
        host.wr(FSP_OFF_IRQ_MASK, 32'h0000_000F, rs);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h1);
        rreg(FSP_OFF_IRQ_STAT);
        check(rd, 32'h0000_0007);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, irq_o}, 32'h0);
        cmd({24'h0, FSP_CMD_CLRERR}, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_001E);
    endtask
    task automatic t_block();
        cmd({24'h0, FSP_CMD_WRITE_DISABLE_COMMAND}, 1'b1);
        rreg(FSP_OFF_IRQ_STAT);
        cmd({24'h0, FSP_CMD_PROG}, 1'b0);
        repeat (2) @(posedge ref_clk_i);
        check({31'h0, status_o[0]}, 32'h0);
        cmd(32'h0000_0001, 1'b0);
        rreg(FSP_OFF_IRQ_STAT);
        check(rd, 32'h0000_0008);
        cmd({24'h0, FSP_CMD_WRITE_ENABLE_COMMAND}, 1'b1);
        cmd({24'h0, FSP_CMD_ERASE}, 1'b0);
        cmd({24'h0, FSP_CMD_WRITE_DISABLE_COMMAND}, 1'b1);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_001E);
        host.wr(FSP_OFF_CONFIG, 32'h0000_0000, rs);
        rreg(FSP_OFF_CONFIG);
        check(rd, 32'h0000_0000);
        rreg(FSP_OFF_STATUS);
        check(rd, 32'h0000_000A);
    endtask
    task automatic t_param();
        for (int a = 8'h12; a <= 8'h25; a++) begin
            host.wr(FSP_OFF_PARAM_ADDR, a, rs);
            rreg(FSP_OFF_PARAM_DATA);
            check({24'h0, rd[7:0]}, {24'h0, exp_param(8'(a))});
        end
    endtask
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_latch();
        t_lock();
        t_vol();
        t_err();
        t_block();
        t_param();
        summarize();
    end
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        n_fail++;
        summarize();
    end
endmodule
